// ===== core/iocm_pkg.sv
// Shared constants and types for the controller mode and address logic.
// Assumes a single 50 MHz clock and a 32-bit classic Wishbone register bus.
package iocm_pkg;

    localparam int CLK_HZ        = 50_000_000;
    localparam int TEST_MS       = 5_000;
    localparam int TEST_CYCLES   = TEST_MS * (CLK_HZ / 1_000);
    localparam int TEST_STEP_DIV = 8;
    localparam int SYNC_W        = 11;

    localparam int ADR_W         = 8;
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_CFG  = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;

    localparam logic [1:0] MODE_OPER = 2'h0;
    localparam logic [1:0] MODE_STBY = 2'h1;
    localparam logic [1:0] MODE_CONF = 2'h2;

    localparam logic [1:0] PAR_NONE  = 2'h0;
    localparam logic [1:0] PAR_EVEN  = 2'h1;
    localparam logic [1:0] PAR_ODD   = 2'h2;

    localparam logic [7:0] FIXED_ADDR = 8'hFF;
    localparam int SW_ADDR_LSB   = 0;
    localparam int SW_ADDR_W     = 6;
    localparam int SW_PAR_LSB    = 6;

    localparam int CFG_W         = 10;
    localparam int STAT_PAR_LSB  = 8;
    localparam int STAT_TEST     = 10;
    localparam int STAT_FAULT    = 11;
    localparam int STAT_HOST     = 12;
    localparam int STAT_SWADR    = 13;
    localparam int STAT_BAUD     = 14;

    typedef enum logic [1:0] {
        ST_TEST = 2'h0,
        ST_OPER = 2'h1,
        ST_STBY = 2'h3,
        ST_CONF = 2'h2
    } iocm_state_t;

    typedef struct packed {
        logic       start_stby;
        logic       baud_hi;
        logic [7:0] soft_addr;
    } iocm_cfg_t;

    localparam iocm_cfg_t CFG_RST = '{
        start_stby: 1'b0, baud_hi: 1'b0, soft_addr: 8'h01};

    typedef struct packed {
        logic green;
        logic stby;
        logic conf;
        logic comms;
        logic fault;
    } iocm_led_t;

endpackage

// ===== core/iocm_mode_ctrl.sv
// Mode supervisor: switch decode, start-up mode, self test, status LEDs
// and safe-state controls for the outputs, alarms and control loops.
// Assumes pins arrive asynchronously and software uses classic Wishbone.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// What this block does
// - Switch positions one to six give a binary unit address.
// - Positions seven and eight select none, even or odd parity.
// - All switches off selects the stored soft address instead.
// - Bit rate 9600 or 19200 comes from stored configuration only.
// - Green operating, yellow standby, yellow config, yellow comms.
// - Red while in reset, on module fault, or memory failure.
// - Power-up defaults to operating mode even with mismatched modules.
// - A stored option makes power-up enter standby instead.
// - A host sensed on the config port at power-up selects config.
// - Reset and power-on run a timed self test stepping LEDs.
// - Inputs keep being scanned in standby.
// - Standby forces digital outputs off, analogue outputs to minimum.
// - Standby disables deviation alarms; full-scale alarms keep working.
// - Returning to operating from standby or config reinitialises deviation alarm blocking only.
// - Mode code reads 0 operating, 1 standby, 2 configuration.
// - Standby to operating needs no instrument reset.
// - Standby holds loop outputs at zero, bumpless return after.
// - Analogue range limits still clamp a zero demand in standby.
// - Writing code two over the link enters configuration mode.
// - Link-entered config stays until operating is commanded.
// - Config may be left even when slots do not match modules.
// - Config-port use also answers at fixed address 255.
module iocm_mode_ctrl
    import iocm_pkg::*;
#(
    parameter int TEST_LEN = TEST_CYCLES
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [7:0]       dil_sw_i,
    input  wire logic             cfg_host_i,
    input  wire logic             net_act_i,
    input  wire logic             cfg_act_i,
    input  wire logic             module_fault_i,
    input  wire logic             nvm_fail_i,
    output logic      [7:0]       unit_addr_o,
    output logic                  alt_addr_en_o,
    output logic      [1:0]       parity_o,
    output logic                  baud_hi_o,
    output logic      [1:0]       mode_o,
    output logic                  self_test_o,
    output logic                  input_scan_o,
    output logic                  dout_off_o,
    output logic                  aout_min_o,
    output logic                  dev_alarm_en_o,
    output logic                  alarm_reinit_o,
    output logic                  loop_hold_o,
    output logic                  loop_bumpless_o,
    output logic                  reconfig_en_o,
    output iocm_led_t             led_o
);

    // Parity field of positions seven and eight; the spare code is none.
    function automatic logic [1:0] parity_of(input logic [1:0] sw);
        logic [1:0] p;
        p = PAR_NONE;
        if (sw == 2'h1) begin
            p = PAR_EVEN;
        end else if (sw == 2'h2) begin
            p = PAR_ODD;
        end
        return p;
    endfunction

    function automatic logic is_reg(input logic [ADR_W-1:0] a,
                                    input logic [7:0]       off);
        return a == off[ADR_W-1:0];
    endfunction

    // Three-stage pin sampling; only stage two feeds stage three.
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] pins_raw;

    assign pins_raw = {cfg_act_i, net_act_i, cfg_host_i, dil_sw_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A pin change counts once stages two and three agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins <= '0;
        end else begin
            for (int i = 0; i < SYNC_W; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pins[i] <= sync3[i];
                end
            end
        end
    end

    logic [7:0] sw_now;
    logic       host_now;
    logic       comms_now;

    assign sw_now    = pins[7:0];
    assign host_now  = pins[8];
    assign comms_now = pins[9] | pins[10];

    // Self test timer and LED walk.
    localparam int STEP_LEN = (TEST_LEN / TEST_STEP_DIV > 0) ?
                              TEST_LEN / TEST_STEP_DIV : 1;

    iocm_state_t state;
    iocm_state_t next_state;
    logic [31:0] test_cnt;
    logic [31:0] step_cnt;
    logic [4:0]  walk;
    logic        test_done;

    assign test_done = (state == ST_TEST) &&
                       (test_cnt == 32'(TEST_LEN - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_cnt <= '0;
            step_cnt <= '0;
            walk     <= 5'h01;
        end else if (state == ST_TEST) begin
            test_cnt <= test_cnt + 32'h1;
            if (step_cnt == 32'(STEP_LEN - 1)) begin
                step_cnt <= '0;
                walk     <= {walk[3:0], walk[4]};
            end else begin
                step_cnt <= step_cnt + 32'h1;
            end
        end
    end

    // Stored configuration and the soft mode request from the bus.
    iocm_cfg_t  cfg;
    logic       bus_req;
    logic       wr_mode;
    logic [1:0] wr_code;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_mode = bus_req & wb_we_i & wb_sel_i[0] &
                     is_reg(wb_adr_i, REG_MODE);
    assign wr_code = wb_dat_i[1:0];

    // Bit rate held in stored configuration.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= CFG_RST;
        end else if (bus_req && wb_we_i && is_reg(wb_adr_i, REG_CFG)) begin
            if (wb_sel_i[0]) begin
                cfg.soft_addr <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg.baud_hi    <= wb_dat_i[8];
                cfg.start_stby <= wb_dat_i[9];
            end
        end
    end

    // Mode sequencing.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_TEST: begin
                if (test_done) begin
                    if (host_now) begin
                        next_state = ST_CONF;
                    end else if (cfg.start_stby) begin
                        next_state = ST_STBY;
                    end else begin
                        next_state = ST_OPER;
                    end
                end
            end
            ST_OPER: begin
                if (wr_mode && wr_code == MODE_STBY) begin
                    next_state = ST_STBY;
                end else if (wr_mode && wr_code == MODE_CONF) begin
                    next_state = ST_CONF;
                end
            end
            ST_STBY: begin
                if (wr_mode && wr_code == MODE_OPER) begin
                    next_state = ST_OPER;
                end else if (wr_mode && wr_code == MODE_CONF) begin
                    next_state = ST_CONF;
                end
            end
            ST_CONF: begin
                if (wr_mode && wr_code == MODE_OPER) begin
                    next_state = ST_OPER;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_TEST;
        end else begin
            state <= next_state;
        end
    end

    // Address, parity and host presence are caught once, as the test ends.
    logic [7:0] sw_cap;
    logic       host_cap;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_cap   <= '0;
            host_cap <= 1'b0;
        end else if (test_done) begin
            sw_cap   <= sw_now;
            host_cap <= host_now;
        end
    end

    logic       sw_zero;
    logic [7:0] sw_addr;

    assign sw_zero = (sw_cap == 8'h00);
    assign sw_addr = {2'h0, sw_cap[SW_ADDR_LSB +: SW_ADDR_W]};

    // The soft address is live so software can move a unit without reset.
    // Binary switch address.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unit_addr_o <= '0;
            parity_o    <= PAR_NONE;
            baud_hi_o   <= 1'b0;
        end else begin
            unit_addr_o <= sw_zero ? cfg.soft_addr : sw_addr;
            parity_o    <= parity_of(sw_cap[SW_PAR_LSB +: 2]);
            baud_hi_o   <= cfg.baud_hi;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_addr_en_o <= 1'b0;
        end else begin
            alt_addr_en_o <= host_cap;
        end
    end

    // Safe-state controls follow the next state so they move with mode_o.
    logic safe;
    logic leave_safe;

    assign safe       = (next_state != ST_OPER);
    assign leave_safe = (state == ST_STBY || state == ST_CONF) &&
                        next_state == ST_OPER;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o      <= MODE_OPER;
            self_test_o <= 1'b1;
        end else begin
            self_test_o <= (next_state == ST_TEST);
            unique case (next_state)
                ST_STBY: mode_o <= MODE_STBY;
                ST_CONF: mode_o <= MODE_CONF;
                default: mode_o <= MODE_OPER;
            endcase
        end
    end

    // Range clamping stays downstream, so a minimum demand becomes the
    // low end of each output range rather than a hard zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_scan_o   <= 1'b1;
            dout_off_o     <= 1'b1;
            aout_min_o     <= 1'b1;
            dev_alarm_en_o <= 1'b0;
            loop_hold_o    <= 1'b1;
            reconfig_en_o  <= 1'b0;
        end else begin
            input_scan_o   <= 1'b1;
            dout_off_o     <= safe;
            aout_min_o     <= safe;
            dev_alarm_en_o <= ~safe;
            loop_hold_o    <= safe;
            reconfig_en_o  <= (next_state == ST_CONF);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_reinit_o  <= 1'b0;
            loop_bumpless_o <= 1'b0;
        end else begin
            alarm_reinit_o  <= leave_safe;
            loop_bumpless_o <= leave_safe;
        end
    end

    // LEDs.
    logic red_now;

    assign red_now = module_fault_i | nvm_fail_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_o <= '{green: 1'b0, stby: 1'b0, conf: 1'b0,
                       comms: 1'b0, fault: 1'b1};
        end else if (next_state == ST_TEST) begin
            led_o <= walk;
        end else begin
            led_o.green <= (next_state == ST_OPER);
            led_o.stby  <= (next_state == ST_STBY);
            led_o.conf  <= (next_state == ST_CONF);
            led_o.comms <= comms_now;
            led_o.fault <= red_now;
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero.
    logic [31:0] rd_data;

    always_comb begin
        rd_data = '0;
        if (is_reg(wb_adr_i, REG_MODE)) begin
            rd_data[1:0] = mode_o;
        end else if (is_reg(wb_adr_i, REG_CFG)) begin
            rd_data[CFG_W-1:0] = cfg;
        end else if (is_reg(wb_adr_i, REG_STAT)) begin
            rd_data[7:0]                 = unit_addr_o;
            rd_data[STAT_PAR_LSB +: 2]   = parity_o;
            rd_data[STAT_TEST]           = self_test_o;
            rd_data[STAT_FAULT]          = red_now;
            rd_data[STAT_HOST]           = host_cap;
            rd_data[STAT_SWADR]          = ~sw_zero;
            rd_data[STAT_BAUD]           = baud_hi_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= (bus_req && !wb_we_i) ? rd_data : 32'h0000_0000;
        end
    end

endmodule // iocm_mode_ctrl

// ===== bench/iocm_mode_ctrl_asserts.sv
// Port checker for the mode supervisor, bound into iocm_mode_ctrl.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module iocm_mode_ctrl_asserts
    import iocm_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [1:0]       mode_o,
    input wire logic             self_test_o,
    input wire logic             input_scan_o,
    input wire logic             dout_off_o,
    input wire logic             aout_min_o,
    input wire logic             dev_alarm_en_o,
    input wire logic             alarm_reinit_o,
    input wire logic             loop_hold_o,
    input wire logic             loop_bumpless_o,
    input wire iocm_led_t        led_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // A request on the bus that commands operating mode.
    logic oper_wr;

    assign oper_wr = wb_cyc_i && wb_stb_i && wb_we_i &&
                     wb_adr_i == REG_MODE && wb_dat_i[1:0] == MODE_OPER;

    sequence conf_left;
        (mode_o == MODE_CONF) ##1 (mode_o != MODE_CONF);
    endsequence

    AST_CONF_EXIT: assert property (conf_left |-> $past(oper_wr))
        else $error("Config mode left without an operating command.");
    AST_MODE_CODE: assert property (mode_o != 2'h3)
        else $error("Mode code out of range.");
    AST_GREEN_LED: assert property (!self_test_o && !$past(self_test_o)
        |-> led_o.green == (mode_o == MODE_OPER))
        else $error("Green lamp disagrees with mode.");
    AST_YELLOW_LED: assert property (!self_test_o && !$past(self_test_o)
        |-> {led_o.stby, led_o.conf}
            == {mode_o == MODE_STBY, mode_o == MODE_CONF})
        else $error("Mode lamps disagree with mode.");
    AST_RED_RESET: assert property (disable iff (1'b0)
        rst_i ##1 rst_i |-> led_o == 5'h01)
        else $error("Lamps wrong while held in reset.");
    AST_SAFE_OUT: assert property (mode_o != MODE_OPER
        |-> dout_off_o && aout_min_o)
        else $error("Outputs not safe outside operating mode.");
    AST_LOOP_HOLD: assert property (mode_o != MODE_OPER |-> loop_hold_o)
        else $error("Loop outputs not held outside operating mode.");
    AST_DEV_ALARM: assert property (dev_alarm_en_o
        |-> mode_o == MODE_OPER && !self_test_o)
        else $error("Deviation alarms live outside operating mode.");
    AST_SCAN: assert property (input_scan_o)
        else $error("Input scanning stopped.");
    AST_REINIT: assert property (alarm_reinit_o
        |-> loop_bumpless_o && mode_o == MODE_OPER ##1 !alarm_reinit_o)
        else $error("Alarm reinit pulse malformed.");
endmodule // iocm_mode_ctrl_asserts

bind iocm_mode_ctrl iocm_mode_ctrl_asserts u_asserts (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .mode_o, .self_test_o, .input_scan_o, .dout_off_o, .aout_min_o,
    .dev_alarm_en_o, .alarm_reinit_o, .loop_hold_o, .loop_bumpless_o,
    .led_o);

// ===== bench/iocm_field_model.sv
// Field-side model: address switch, config-port host and its traffic.
// Assumes the bench changes switch and host settings only under reset.
`timescale 1ns/1ps
module iocm_field_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       self_test_i,
    input  wire logic [7:0] sw_set_i,
    input  wire logic       host_set_i,
    input  wire logic       talk_i,
    output logic      [7:0] dil_sw_o,
    output logic            cfg_host_o,
    output logic            cfg_act_o
);
    always_ff @(posedge clk_i) begin
        dil_sw_o   <= sw_set_i;
        cfg_host_o <= host_set_i;
        cfg_act_o  <= talk_i && !rst_i && !self_test_i;
    end
endmodule // iocm_field_model

// ===== bench/testbench.sv
// Self-checking bench for iocm_mode_ctrl over classic Wishbone.
// Assumes a short self test (TEST_LEN 64) and a 50 MHz clock.
`timescale 1ns/1ps
module testbench
    import iocm_pkg::*;
;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic net_act_i, module_fault_i, nvm_fail_i, host_set, talk;
    logic cfg_host_i, cfg_act_i, alt_addr_en_o, baud_hi_o, self_test_o;
    logic input_scan_o, dout_off_o, aout_min_o, dev_alarm_en_o;
    logic alarm_reinit_o, loop_hold_o, loop_bumpless_o, reconfig_en_o;
    logic [7:0]  wb_adr_i, sw_set, dil_sw_i, unit_addr_o;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [1:0]  parity_o, mode_o, e;
    iocm_led_t   led_o;
    int          err_total, compares, reinit_n;
    logic [7:0]  sw_tab[5] = '{8'h45, 8'h81, 8'hC3, 8'h3F, 8'h00};
    logic [7:0]  ad_tab[5] = '{8'h05, 8'h01, 8'h03, 8'h3F, 8'h01};
    logic [1:0]  pa_tab[5] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    logic [1:0]  mw[8] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h1, 2'h2};
    logic [1:0]  me[8] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};

    iocm_mode_ctrl #(.TEST_LEN(64)) u_iocm_mode_ctrl (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dil_sw_i,
        .cfg_host_i, .net_act_i, .cfg_act_i, .module_fault_i,
        .nvm_fail_i, .unit_addr_o, .alt_addr_en_o, .parity_o,
        .baud_hi_o, .mode_o, .self_test_o, .input_scan_o, .dout_off_o,
        .aout_min_o, .dev_alarm_en_o, .alarm_reinit_o, .loop_hold_o,
        .loop_bumpless_o, .reconfig_en_o, .led_o);

    iocm_field_model u_iocm_field_model (
        .clk_i, .rst_i, .self_test_i(self_test_o), .sw_set_i(sw_set),
        .host_set_i(host_set), .talk_i(talk), .dil_sw_o(dil_sw_i),
        .cfg_host_o(cfg_host_i), .cfg_act_o(cfg_act_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) if (alarm_reinit_o === 1'b1) reinit_n++;

    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled, then releases it.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic boot(input logic [7:0] s, input logic h);
        @(posedge clk_i);
        rst_i    <= 1'b1;
        sw_set   <= s;
        host_set <= h;
        repeat (8) @(posedge clk_i);
        chk(led_o, 32'h01);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(self_test_o, 1'b1);
    endtask

    // Only the watchdog ends a self test that never finishes.
    task automatic settle;
        while (self_test_o !== 1'b0) begin
            @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        final_report;
    end

    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, host_set, talk} = 6'h20;
        {net_act_i, module_fault_i, nvm_fail_i} = 3'h0;
        {wb_adr_i, sw_set, wb_sel_i, wb_dat_i} = '0;
        {err_total, compares, reinit_n} = '0;
        for (int i = 0; i < 5; i++) begin
            module_fault_i <= (i == 4);
            boot(sw_tab[i], 1'b0);
            settle;
            chk(unit_addr_o, ad_tab[i]);
            chk(parity_o, pa_tab[i]);
        end
        chk(mode_o, MODE_OPER);
        chk(led_o.fault, 1'b1);
        module_fault_i <= 1'b0;
        bus(1'b1, REG_CFG, 32'h0000_01C8);
        repeat (2) @(posedge clk_i);
        chk(unit_addr_o, 8'hC8);
        chk(baud_hi_o, 1'b1);
        bus(1'b0, REG_STAT, 32'h0);
        chk(rd, 32'h0000_40C8);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        // Covers standby to config as well as operating to config.
        for (int i = 0; i < 8; i++) begin
            module_fault_i <= (i == 5);
            bus(1'b1, REG_MODE, {30'h0, mw[i]});
            e = me[i];
            chk(mode_o, e);
            chk(dout_off_o, e != MODE_OPER);
            chk(dev_alarm_en_o, e == MODE_OPER);
            chk(reconfig_en_o, e == MODE_CONF);
            chk(led_o[4:2], {e == 2'h0, e == 2'h1, e == 2'h2});
            bus(1'b0, REG_MODE, 32'h0);
            chk(rd[1:0], e);
        end
        chk(reinit_n, 2);
        module_fault_i <= 1'b0;
        net_act_i <= 1'b1;
        talk <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(led_o.comms, 1'b1);
        nvm_fail_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(led_o.fault, 1'b1);
        {net_act_i, talk, nvm_fail_i} <= 3'h0;
        // Port activity passes the field model's flop before the pins.
        repeat (8) @(posedge clk_i);
        chk(led_o[1:0], 2'h0);
        boot(8'h01, 1'b0);
        bus(1'b1, REG_CFG, 32'h0000_0201);
        settle;
        chk(mode_o, MODE_STBY);
        chk(input_scan_o, 1'b1);
        chk(loop_hold_o, 1'b1);
        boot(8'h01, 1'b1);
        settle;
        chk(mode_o, MODE_CONF);
        chk(alt_addr_en_o, 1'b1);
        final_report;
    end
endmodule // testbench
